// file: verilog/twi_pkg.sv
// Package: register map, field positions, reset values, bus constants and types of the two-wire controller
`default_nettype none
package twi_pkg;
  // ==========================================================================
  // Register byte addresses
  localparam logic [11:0] ADDR_CONTROL  = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_OWN_ADDR = 12'h008;
  localparam logic [11:0] ADDR_TRANSMIT = 12'h00C;
  localparam logic [11:0] ADDR_RECEIVE  = 12'h010;
  localparam logic [11:0] ADDR_SYSTEM   = 12'h014;
  localparam logic [11:0] ADDR_BAUD     = 12'h018;
  // ==========================================================================
  // Control bit positions
  localparam int CB_ENABLE  = 15;
  localparam int CB_IDLE    = 13;
  localparam int CB_REL     = 12;
  localparam int CB_STRICT  = 11;
  localparam int CB_WIDE    = 10;
  localparam int CB_EDGE    = 9;
  localparam int CB_LEVELS  = 8;
  localparam int CB_BCAST   = 7;
  localparam int CB_STRETCH = 6;
  localparam int CB_ACKV    = 5;
  localparam int CB_ACKSEQ  = 4;
  localparam int CB_RECV    = 3;
  localparam int CB_STOP    = 2;
  localparam int CB_RESTART = 1;
  localparam int CB_START   = 0;
  // ==========================================================================
  // Status bit positions
  localparam int SB_ACKRX   = 15;
  localparam int SB_TXPROG  = 14;
  localparam int SB_COLL    = 10;
  localparam int SB_BCAST   = 9;
  localparam int SB_WIDE    = 8;
  localparam int SB_WCLASH  = 7;
  localparam int SB_OVF     = 6;
  localparam int SB_DATA    = 5;
  localparam int SB_STOPSN  = 4;
  localparam int SB_STARTSN = 3;
  localparam int SB_READ    = 2;
  localparam int SB_RFULL   = 1;
  localparam int SB_TFULL   = 0;
  // ==========================================================================
  // Reset values
  localparam logic [15:0] CONTROL_RESET = 16'h1000;
  localparam logic [15:0] STATUS_RESET  = 16'h0000;
  localparam logic [15:0] BAUD_RESET    = 16'h0031;
  localparam logic [9:0]  OWN_RESET     = 10'h000;
  localparam logic [31:0] RESP_UNMAPPED = 32'h0000_0000;
  // ==========================================================================
  // Bus constants
  localparam logic [6:0] GENERAL_CALL = 7'h00;
  localparam logic [4:0] WIDE_PREFIX  = 5'h1E;
  // ==========================================================================
  // Types
  typedef struct packed {
    logic sda;
    logic scl;
  } line_s;
  typedef enum logic [7:0] {
    M_IDLE  = 8'h01,
    M_START = 8'h02,
    M_RSTRT = 8'h04,
    M_STOP  = 8'h08,
    M_TX    = 8'h10,
    M_RX    = 8'h20,
    M_ACK   = 8'h40,
    M_LOST  = 8'h80
  } master_e;
endpackage
`default_nettype wire

// file: verilog/twi_ctrl.sv
// Two-wire bus controller: master sequencer, slave receiver/transmitter, AHB-Lite registers
//
// Operation
// (R01) Enable bit gives the module the data and clock pins; off returns them to ports.
// (R02) Idle-halt bit stops the module while the device idles.
// (R03) With stretching on, software holds/releases clock; hardware clears release at slave tx/rx.
// (R04) With stretching off, release bit takes only ones; cleared at slave transmit start.
// (R05) Strict bit blocks reserved addresses as slave and as master.
// (R06) Wide-address select makes own address ten bits, else seven.
// (R07) Broadcast enable with reception answers the general call address.
// (R08) Ack request drives ack cycle with ack value; cleared at cycle end.
// (R09) Receive request takes one byte; cleared after eighth bit.
// (R10) Start, restart and stop requests make their conditions; cleared when done.
// (R11) Master transmit records slave ack as ack-received flag.
// (R12) Transmit-in-progress spans eight bits plus ack.
// (R13) Bus collision in master operation sets sticky collision flag; only master transmit data bits are checked.
// (R14) Broadcast-seen and wide-match flags set on match, clear on stop.
// (R15) Transmit write while busy fails and sets write clash flag.
// (R16) Byte completing over unread receive data sets overflow flag.
// (R17) Slave data-or-address flag clears on address, sets on data.
// (R18) Start-seen and stop-seen flags show the last condition detected.
// (R19) Slave records read/write direction from address byte.
// (R20) Receive full sets on byte stored, clears on software read.
// (R21) Transmit full sets on software write, clears when transmission completes.
// (R22) Software avoids register access right after disabling with 1:1 divisor.
// (R23) Clearable flags clear on written zero; a written one leaves them.
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`default_nettype none
module twi_ctrl
  import twi_pkg::*;
(
  input  wire logic        hclk,        // Bus clock
  input  wire logic        hresetn,     // Async reset, active low
  input  wire logic        hsel,        // Slave select
  input  wire logic [31:0] haddr,       // Address
  input  wire logic [1:0]  htrans,      // Transfer type
  input  wire logic        hwrite,      // Write
  input  wire logic [2:0]  hsize,       // Size
  input  wire logic [31:0] hwdata,      // Write data
  input  wire logic        hready,      // Bus ready
  output logic      [31:0] hrdata,      // Read data
  output logic             hreadyout,   // Slave ready
  output logic             hresp,       // Response
  input  wire logic        device_idle, // Device is in idle mode
  input  wire logic        sda_in,      // Data line level
  output logic             sda_out,     // Data drive value (always 0)
  output logic             sda_oe_n,    // Data pulled low when 0
  input  wire logic        scl_in,      // Clock line level
  output logic             scl_out,     // Clock drive value (always 0)
  output logic             scl_oe_n,    // Clock pulled low when 0
  output logic             pins_owned   // Module owns the pins
);
  // ==========================================================================
  // Registers and state
  logic [15:0] ctl_r, sts_r;
  logic [9:0]  own_r;
  logic [7:0]  tx_r, rx_r, shf_r;
  logic [15:0] baud_r, bcnt_r;
  logic [3:0]  bit_r, sl_bit_r;
  logic [1:0]  ph_r;
  master_e     ms_r;
  logic        sl_act_r, sl_tx_r, sl_addr_r, sl_second_r, sl_ack_r, sl_nack_r;
  logic        sl_hold_r, sda_drv_r, scl_drv_r;
  logic [1:0]  sda_s_r, scl_s_r;
  logic        sda_d_r, scl_d_r;
  logic        ap_wr_r, ap_rd_r;
  logic [11:0] ap_a_r;
  line_s       ln;

  // ==========================================================================
  // Input synchronisers and edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_s_r <= 2'h3;
      scl_s_r <= 2'h3;
      sda_d_r <= 1'b1;
      scl_d_r <= 1'b1;
    end else begin
      sda_s_r <= {sda_s_r[0], sda_in};
      scl_s_r <= {scl_s_r[0], scl_in};
      sda_d_r <= sda_s_r[1];
      scl_d_r <= scl_s_r[1];
    end
  end
  assign ln.sda = sda_s_r[1];
  assign ln.scl = scl_s_r[1];

  wire active   = ctl_r[CB_ENABLE] && !(ctl_r[CB_IDLE] && device_idle); // R01 R02
  wire scl_rise = active && ln.scl && !scl_d_r;
  wire scl_fall = active && !ln.scl && scl_d_r;
  wire start_dt = active && ln.scl && scl_d_r && !ln.sda && sda_d_r;
  wire stop_dt  = active && ln.scl && scl_d_r && ln.sda && !sda_d_r;
  wire tick     = active && (bcnt_r == 16'h0000);

  // ==========================================================================
  // Bus decode
  wire ap_take = hsel && hready && htrans[1];
  wire wr_ctl  = ap_wr_r && ap_a_r == ADDR_CONTROL;
  wire wr_sts  = ap_wr_r && ap_a_r == ADDR_STATUS;
  wire wr_own  = ap_wr_r && ap_a_r == ADDR_OWN_ADDR;
  wire wr_tx   = ap_wr_r && ap_a_r == ADDR_TRANSMIT;
  wire wr_baud = ap_wr_r && ap_a_r == ADDR_BAUD;
  wire rd_rx   = ap_rd_r && ap_a_r == ADDR_RECEIVE;
  wire busy    = (ms_r != M_IDLE) || sl_act_r && sl_tx_r || sts_r[SB_TFULL];
  wire tx_ok   = wr_tx && !busy;
  wire clash   = wr_tx && busy; // R15
  wire m_busy  = ms_r != M_IDLE;

  // Reserved address space: 0000xxx and 1111xxx, general call excepted
  function automatic logic reserved(input logic [6:0] a);
    reserved = (a[6:3] == 4'h0 && a != GENERAL_CALL) || a[6:3] == 4'hF;
  endfunction

  // ==========================================================================
  // Slave address decode on received byte
  wire [6:0] rx_adr   = shf_r[7:1];
  wire       gc_hit   = ctl_r[CB_BCAST] && rx_adr == GENERAL_CALL && !sl_second_r; // R07
  wire       own7_hit = !ctl_r[CB_WIDE] && rx_adr == own_r[6:0]
                        && !(ctl_r[CB_STRICT] && reserved(rx_adr)); // R05 R06
  wire       wide1    = ctl_r[CB_WIDE] && shf_r[7:3] == WIDE_PREFIX && shf_r[2:1] == own_r[9:8];
  wire       wide2    = ctl_r[CB_WIDE] && sl_second_r && shf_r == own_r[7:0]; // R06
  wire       tx_rsv   = ctl_r[CB_STRICT] && reserved(hwdata[7:1]); // R05

  // ==========================================================================
  // Register bus address phase and registered read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r <= 1'b0;
      ap_rd_r <= 1'b0;
      ap_a_r  <= 12'h000;
      hrdata  <= RESP_UNMAPPED;
    end else begin
      ap_wr_r <= ap_take && hwrite;
      ap_rd_r <= ap_take && !hwrite;
      ap_a_r  <= haddr[11:0];
      if (ap_take && !hwrite) begin
        case (haddr[11:0])
          ADDR_CONTROL:  hrdata <= {16'h0000, ctl_r};
          ADDR_STATUS:   hrdata <= {16'h0000, sts_r};
          ADDR_OWN_ADDR: hrdata <= {22'h000000, own_r};
          ADDR_TRANSMIT: hrdata <= {24'h000000, tx_r};
          ADDR_RECEIVE:  hrdata <= {24'h000000, rx_r};
          ADDR_BAUD:     hrdata <= {16'h0000, baud_r};
          default:       hrdata <= RESP_UNMAPPED;
        endcase
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ==========================================================================
  // Quarter-bit tick divider and simple registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bcnt_r <= BAUD_RESET;
      baud_r <= BAUD_RESET;
      own_r  <= OWN_RESET;
      tx_r   <= 8'h00;
    end else begin
      bcnt_r <= (!m_busy || tick) ? baud_r : bcnt_r - 16'h0001;
      if (wr_baud) baud_r <= hwdata[15:0];
      if (wr_own)  own_r  <= hwdata[9:0];
      if (tx_ok)   tx_r   <= hwdata[7:0];
    end
  end

  // ==========================================================================
  // Master sequencer: four ticks per bit (ph 0 low, 1 set data, 2 high, 3 sample)
  wire       ph_end   = tick && ph_r == 2'h3;
  wire       m_tx_go  = tx_ok && !tx_rsv && ms_r == M_IDLE;
  // Only data bits of a transmit count: the ack slot and stop lag are not collisions
  wire       lost     = ms_r == M_TX && bit_r < 4'h8 && sda_drv_r && !ln.sda && ph_r == 2'h3 && tick; // R13
  wire       seq_done = ph_end;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_r      <= M_IDLE;
      ph_r      <= 2'h0;
      bit_r     <= 4'h0;
      sda_drv_r <= 1'b1;
      scl_drv_r <= 1'b1;
    end else if (!active) begin
      ms_r      <= M_IDLE;
      sda_drv_r <= 1'b1;
      scl_drv_r <= 1'b1;
    end else begin
      if (tick) ph_r <= ph_r + 2'h1;
      case (ms_r)
        M_IDLE: begin
          ph_r  <= 2'h0;
          bit_r <= 4'h0;
          if (ctl_r[CB_START]) ms_r <= M_START; // R10
          else if (ctl_r[CB_RESTART]) ms_r <= M_RSTRT;
          else if (ctl_r[CB_STOP]) ms_r <= M_STOP;
          else if (m_tx_go) ms_r <= M_TX; // R12
          else if (ctl_r[CB_RECV]) ms_r <= M_RX; // R09
          else if (ctl_r[CB_ACKSEQ]) ms_r <= M_ACK; // R08
        end
        M_START: begin
          if (tick && ph_r == 2'h1) sda_drv_r <= 1'b0;
          if (tick && ph_r == 2'h3) scl_drv_r <= 1'b0;
          if (seq_done) ms_r <= M_IDLE;
        end
        M_RSTRT: begin
          if (tick && ph_r == 2'h0) sda_drv_r <= 1'b1;
          if (tick && ph_r == 2'h1) scl_drv_r <= 1'b1;
          if (tick && ph_r == 2'h2) sda_drv_r <= 1'b0;
          if (seq_done) begin
            scl_drv_r <= 1'b0;
            ms_r      <= M_IDLE;
          end
        end
        M_STOP: begin
          if (tick && ph_r == 2'h0) sda_drv_r <= 1'b0;
          if (tick && ph_r == 2'h1) scl_drv_r <= 1'b1;
          if (tick && ph_r == 2'h2) sda_drv_r <= 1'b1;
          if (seq_done) ms_r <= M_IDLE;
        end
        M_TX, M_RX, M_ACK: begin
          if (tick && ph_r == 2'h1) begin
            sda_drv_r <= ms_r == M_TX ? (bit_r < 4'h8 ? tx_r[3'h7 - bit_r[2:0]] : 1'b1)
                       : ms_r == M_ACK ? ctl_r[CB_ACKV] : 1'b1; // R08
          end
          if (tick && ph_r == 2'h2) scl_drv_r <= 1'b1;
          if (seq_done) begin
            scl_drv_r <= 1'b0;
            bit_r     <= bit_r + 4'h1;
            if (ms_r == M_ACK || (ms_r == M_RX && bit_r == 4'h7) || (ms_r == M_TX && bit_r == 4'h8))
              ms_r <= M_IDLE;
          end
          if (lost && ms_r == M_TX) ms_r <= M_LOST;
        end
        M_LOST: begin
          sda_drv_r <= 1'b1;
          scl_drv_r <= 1'b1;
          ms_r      <= M_IDLE;
        end
        default: ms_r <= M_IDLE;
      endcase
    end
  end
  wire m_rx_bit  = ms_r == M_RX && seq_done;
  wire m_rx_done = m_rx_bit && bit_r == 4'h7;
  wire m_tx_ack  = ms_r == M_TX && seq_done && bit_r == 4'h8;

  // ==========================================================================
  // Slave engine: shift, decide and step bit count on clock rise; release ack on fall
  wire sl_byte   = sl_act_r && !sl_tx_r && scl_rise && sl_bit_r == 4'h7 && !m_busy;
  wire sl_adr_ok = sl_addr_r && (gc_hit || own7_hit || wide1 || wide2);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shf_r       <= 8'h00;
      sl_act_r    <= 1'b0;
      sl_tx_r     <= 1'b0;
      sl_addr_r   <= 1'b0;
      sl_second_r <= 1'b0;
      sl_ack_r    <= 1'b0;
      sl_nack_r   <= 1'b0;
      sl_hold_r   <= 1'b0;
      sl_bit_r    <= 4'h0;
    end else if (!active || stop_dt) begin
      sl_act_r    <= 1'b0;
      sl_ack_r    <= 1'b0;
      sl_second_r <= 1'b0;
      sl_bit_r    <= 4'h0;
    end else if (start_dt && !m_busy) begin
      sl_act_r  <= 1'b1;
      sl_addr_r <= 1'b1;
      sl_tx_r   <= 1'b0;
      sl_ack_r  <= 1'b0;
      shf_r     <= 8'h00;
      sl_bit_r  <= 4'h0;
    end else begin
      if (sl_act_r && scl_rise && !m_busy) sl_bit_r <= (sl_bit_r == 4'h8) ? 4'h0 : sl_bit_r + 4'h1;
      if ((scl_rise && !sl_tx_r && !m_busy) || m_rx_bit) shf_r <= {shf_r[6:0], ln.sda};
      if (sl_byte) begin
        sl_ack_r  <= !sl_addr_r || sl_adr_ok;
        sl_addr_r <= 1'b0;
        if (sl_addr_r) begin
          sl_act_r    <= sl_adr_ok;
          sl_tx_r     <= sl_adr_ok && shf_r[6] && !wide1 && !gc_hit;
          sl_second_r <= wide1 && !shf_r[6];
        end
      end
      if (sl_ack_r && scl_fall) sl_ack_r <= 1'b0;
      if (sl_tx_r && scl_rise && sl_bit_r == 4'h8) sl_nack_r <= ln.sda;
      sl_hold_r <= sl_byte && ctl_r[CB_STRETCH];
    end
  end

  // ==========================================================================
  // Control register with hardware clears
  logic [15:0] ctl_nxt;
  always_comb begin
    ctl_nxt = ctl_r;
    if (wr_ctl) begin
      ctl_nxt = hwdata[15:0] & 16'hBFFF;
      if (!ctl_r[CB_STRETCH]) ctl_nxt[CB_REL] = ctl_r[CB_REL] | hwdata[CB_REL]; // R04
    end
    if (sl_byte && sl_adr_ok && shf_r[6]) ctl_nxt[CB_REL] = 1'b0; // R03 R04
    if (sl_byte && ctl_r[CB_STRETCH] && !sl_addr_r) ctl_nxt[CB_REL] = 1'b0; // R03
    if (ms_r == M_START && seq_done) ctl_nxt[CB_START] = 1'b0; // R10
    if (ms_r == M_RSTRT && seq_done) ctl_nxt[CB_RESTART] = 1'b0;
    if (ms_r == M_STOP && seq_done) ctl_nxt[CB_STOP] = 1'b0;
    if (m_rx_done) ctl_nxt[CB_RECV] = 1'b0; // R09
    if (ms_r == M_ACK && seq_done) ctl_nxt[CB_ACKSEQ] = 1'b0; // R08
    if (ms_r == M_LOST) ctl_nxt[4:0] = 5'h00;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctl_r <= CONTROL_RESET;
    else ctl_r <= ctl_nxt;
  end

  // ==========================================================================
  // Status register: hardware sets beat software clears
  logic [15:0] sts_nxt;
  wire rx_store = m_rx_done || (sl_byte && (!sl_addr_r || sl_adr_ok));
  always_comb begin
    sts_nxt = sts_r;
    if (wr_sts) begin
      sts_nxt[SB_COLL]   = sts_r[SB_COLL] & hwdata[SB_COLL]; // R23
      sts_nxt[SB_WCLASH] = sts_r[SB_WCLASH] & hwdata[SB_WCLASH];
      sts_nxt[SB_OVF]    = sts_r[SB_OVF] & hwdata[SB_OVF];
      sts_nxt[SB_STOPSN] = sts_r[SB_STOPSN] & hwdata[SB_STOPSN];
      sts_nxt[SB_STARTSN] = sts_r[SB_STARTSN] & hwdata[SB_STARTSN];
    end
    if (m_tx_go) sts_nxt[SB_TXPROG] = 1'b1; // R12
    if (m_tx_ack) begin
      sts_nxt[SB_TXPROG] = 1'b0; // R12
      sts_nxt[SB_ACKRX]  = ln.sda; // R11
      sts_nxt[SB_TFULL]  = 1'b0; // R21
    end
    if (sl_tx_r && scl_rise && sl_bit_r == 4'h7) sts_nxt[SB_TFULL] = 1'b0; // R21
    if (lost) sts_nxt[SB_COLL] = 1'b1; // R13
    if (clash) sts_nxt[SB_WCLASH] = 1'b1; // R15
    if (tx_ok) sts_nxt[SB_TFULL] = 1'b1; // R21
    if (stop_dt) begin
      sts_nxt[SB_BCAST]   = 1'b0; // R14
      sts_nxt[SB_WIDE]    = 1'b0;
      sts_nxt[SB_STOPSN]  = 1'b1; // R18
      sts_nxt[SB_STARTSN] = 1'b0;
    end
    if (start_dt) begin
      sts_nxt[SB_STOPSN]  = 1'b0; // R18
      sts_nxt[SB_STARTSN] = 1'b1;
    end
    if (sl_byte && sl_addr_r && gc_hit) sts_nxt[SB_BCAST] = 1'b1; // R14 R07
    if (sl_byte && wide2) sts_nxt[SB_WIDE] = 1'b1; // R14
    if (sl_byte && sl_adr_ok) begin
      sts_nxt[SB_DATA] = 1'b0; // R17
      if (!wide2) sts_nxt[SB_READ] = shf_r[6]; // R19
    end
    if (sl_byte && !sl_addr_r) sts_nxt[SB_DATA] = 1'b1; // R17
    if (rd_rx) sts_nxt[SB_RFULL] = 1'b0; // R20
    if (rx_store) begin
      if (sts_r[SB_RFULL]) sts_nxt[SB_OVF] = 1'b1; // R16
      else sts_nxt[SB_RFULL] = 1'b1; // R20
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sts_r <= STATUS_RESET;
      rx_r  <= 8'h00;
    end else begin
      sts_r <= sts_nxt;
      if (rx_store && !sts_r[SB_RFULL]) rx_r <= {shf_r[6:0], ln.sda}; // R20
    end
  end

  // ==========================================================================
  // Slave transmit data and pin drive
  logic sl_sda_nxt;
  always_comb begin
    sl_sda_nxt = 1'b1;
    if (sl_ack_r) sl_sda_nxt = 1'b0;
    else if (sl_tx_r && sl_act_r && sl_bit_r < 4'h8) sl_sda_nxt = tx_r[3'h7 - sl_bit_r[2:0]];
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_out    <= 1'b0;
      scl_out    <= 1'b0;
      sda_oe_n   <= 1'b1;
      scl_oe_n   <= 1'b1;
      pins_owned <= 1'b0;
    end else begin
      sda_out    <= 1'b0;
      scl_out    <= 1'b0;
      pins_owned <= ctl_r[CB_ENABLE]; // R01
      sda_oe_n   <= !active || (sda_drv_r && sl_sda_nxt);
      scl_oe_n   <= !active || (scl_drv_r && (ctl_r[CB_REL] || !sl_act_r) && !sl_hold_r); // R03
    end
  end
endmodule
`default_nettype wire

// file: verif/twi_slave_model.sv
// Partner: slave on the wire that acknowledges each byte
`default_nettype none
module twi_slave_model (
  input  wire logic scl,     // Clock line level
  input  wire logic sda,     // Data line level
  input  wire logic ack_on,  // Answer bytes with an acknowledge
  output logic      sda_low  // Pull data line low
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  initial begin
    cnt = 0;
    sda_low = 1'b0;
  end
  // Start or repeated start restarts the bit count
  always @(negedge sda) begin
    if (scl) cnt = 0;
  end
  always @(posedge scl) begin
    cnt = cnt + 1;
  end
  // Data line released outside the acknowledge slot; pull-up makes it high
  always @(negedge scl) begin
    if (cnt == 8) sda_low = ack_on;
    else if (cnt >= 9) begin
      sda_low = 1'b0;
      cnt = 0;
    end
  end
endmodule
`default_nettype wire

// file: verif/twi_ctrl_asserts.sv
// Checker: bus answers, read data and pin drive of the two-wire controller
`default_nettype none
module twi_ctrl_asserts
  import twi_pkg::*;
(
  input wire logic        hclk,       // Clock
  input wire logic        hresetn,    // Reset, active low
  input wire logic        hsel,       // Select
  input wire logic [31:0] haddr,      // Address
  input wire logic [1:0]  htrans,     // Transfer type
  input wire logic        hwrite,     // Write
  input wire logic [31:0] hwdata,     // Write data
  input wire logic        hready,     // Bus ready
  input wire logic [31:0] hrdata,     // Read data
  input wire logic        hreadyout,  // Slave ready
  input wire logic        hresp,      // Response
  input wire logic        sda_out,    // Data drive value
  input wire logic        sda_oe_n,   // Data pulled low when 0
  input wire logic        scl_out,    // Clock drive value
  input wire logic        scl_oe_n,   // Clock pulled low when 0
  input wire logic        pins_owned  // Module owns the pins
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================================
  // Data phase tracking
  logic        tk;
  logic        rd_q;
  logic        wr_q;
  logic        en_q;
  logic [11:0] a_q;
  assign tk = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      a_q  <= 12'h000;
      en_q <= 1'b0;
    end else begin
      rd_q <= tk && !hwrite;
      wr_q <= tk && hwrite;
      a_q  <= tk ? haddr[11:0] : a_q;
      en_q <= (wr_q && a_q == ADDR_CONTROL) ? hwdata[CB_ENABLE] : en_q;
    end
  end
  // ==========================================================================
  // Assertions
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  drive_zero_a: assert property (!sda_out && !scl_out) else $error("pin drive value not low");
  pins_free_a: assert property (!pins_owned |-> sda_oe_n && scl_oe_n) else $error("pin pulled while off");
  enable_mirror_a: assert property (wr_q && a_q == ADDR_CONTROL |=> ##[0:1] pins_owned == en_q)
    else $error("pin ownership does not follow enable");
  read_hold_a: assert property (!(tk && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
  upper_zero_a: assert property (rd_q |-> hrdata[31:16] == 16'h0000) else $error("upper half not zero");
  status_gap_a: assert property (rd_q && a_q == ADDR_STATUS |-> hrdata[13:11] == 3'h0)
    else $error("status gap bits set");
  last_cond_a: assert property (rd_q && a_q == ADDR_STATUS |-> !(hrdata[SB_STOPSN] && hrdata[SB_STARTSN]))
    else $error("start and stop both shown");
  unmapped_zero_a: assert property (rd_q && (a_q == ADDR_SYSTEM || a_q > ADDR_BAUD) |-> hrdata == RESP_UNMAPPED)
    else $error("unmapped read not zero");
  cover property ($rose(pins_owned));
  cover property ($fell(sda_oe_n) && scl_oe_n);
  cover property (rd_q && a_q == ADDR_STATUS);
endmodule
bind twi_ctrl twi_ctrl_asserts twi_ctrl_asserts_i (.*);
`default_nettype wire

// file: verif/twi_ctrl_tb.sv
// Testbench: register-level scenarios of the two-wire controller
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module twi_ctrl_tb
  import twi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        device_idle = 1'b0;
  logic        ack_on = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        sda_out;
  logic        sda_oe_n;
  logic        scl_out;
  logic        scl_oe_n;
  logic        pins_owned;
  logic        sda_low;
  wire         hready = hreadyout;
  wire         sda_in = sda_oe_n & ~sda_low;
  wire         scl_in = scl_oe_n;
  int          error_cnt = 0;
  int          num_checks = 0;
  twi_ctrl twi_ctrl_i (.*);
  twi_slave_model twi_slave_model_i (.scl(scl_in), .sda(sda_in), .ack_on(ack_on), .sda_low(sda_low));
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  // ==========================================================================
  // Bus tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 100) begin
        error_cnt++;
        test_done();
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    haddr  <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  // Poll a register until the masked bits read zero
  task automatic wait_clr(input logic [11:0] a, input logic [31:0] m);
    int n;
    n = 0;
    bus(1'b0, a, 32'h0);
    while ((rd & m) !== 32'h0) begin
      n++;
      if (n > 2000) begin
        error_cnt++;
        test_done();
      end
      bus(1'b0, a, 32'h0);
    end
  endtask
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    hsel    <= 1'b1;
    bus(1'b0, ADDR_CONTROL, 32'h0);
    `CHK(rd, {16'h0, CONTROL_RESET})
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd, {16'h0, STATUS_RESET})
    bus(1'b0, ADDR_BAUD, 32'h0);
    `CHK(rd, {16'h0, BAUD_RESET})
    bus(1'b0, 12'h020, 32'h0);
    `CHK(rd, RESP_UNMAPPED)
    bus(1'b1, ADDR_BAUD, 32'h1);
    $display("test reset done");
    bus(1'b1, ADDR_CONTROL, 32'h8001);
    wait_clr(ADDR_CONTROL, 32'h1F);
    `CHK(rd, 32'h9000)
    `CHK(pins_owned, 1'b1)
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[SB_STARTSN], 1'b1)
    $display("test start done");
    bus(1'b1, ADDR_TRANSMIT, 32'hA6);
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[SB_TFULL], 1'b1)
    `CHK(rd[SB_TXPROG], 1'b1)
    bus(1'b1, ADDR_TRANSMIT, 32'h55);
    wait_clr(ADDR_STATUS, 32'h1 << SB_TXPROG);
    `CHK(rd[SB_WCLASH], 1'b1)
    `CHK(rd[SB_ACKRX], 1'b0)
    `CHK(rd[SB_TFULL], 1'b0)
    `CHK(rd[SB_COLL], 1'b0)
    bus(1'b1, ADDR_STATUS, 32'hFFFF);
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[SB_WCLASH], 1'b1)
    bus(1'b1, ADDR_STATUS, 32'hFF7F);
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[SB_WCLASH], 1'b0)
    ack_on <= 1'b0;
    bus(1'b1, ADDR_TRANSMIT, 32'h3C);
    wait_clr(ADDR_STATUS, 32'h1 << SB_TXPROG);
    `CHK(rd[SB_ACKRX], 1'b1)
    $display("test transmit done");
    bus(1'b1, ADDR_CONTROL, 32'h8008);
    wait_clr(ADDR_CONTROL, 32'h8);
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[SB_RFULL], 1'b1)
    bus(1'b1, ADDR_CONTROL, 32'h8030);
    wait_clr(ADDR_CONTROL, 32'h10);
    `CHK(rd, 32'h9020)
    bus(1'b1, ADDR_CONTROL, 32'h8008);
    wait_clr(ADDR_CONTROL, 32'h8);
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[SB_OVF], 1'b1)
    bus(1'b0, ADDR_RECEIVE, 32'h0);
    `CHK(rd, 32'hFF)
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[SB_RFULL], 1'b0)
    $display("test receive done");
    bus(1'b1, ADDR_CONTROL, 32'h8004);
    wait_clr(ADDR_CONTROL, 32'h4);
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[SB_STOPSN], 1'b1)
    `CHK(rd[SB_STARTSN], 1'b0)
    bus(1'b1, ADDR_CONTROL, 32'h8040);
    bus(1'b0, ADDR_CONTROL, 32'h0);
    `CHK(rd, 32'h9040)
    bus(1'b1, ADDR_CONTROL, 32'h8040);
    bus(1'b0, ADDR_CONTROL, 32'h0);
    `CHK(rd, 32'h8040)
    $display("test stretch done");
    device_idle <= 1'b1;
    bus(1'b1, ADDR_CONTROL, 32'hA001);
    repeat (20) @(posedge hclk);
    bus(1'b0, ADDR_CONTROL, 32'h0);
    `CHK(rd[CB_START], 1'b1)
    device_idle <= 1'b0;
    wait_clr(ADDR_CONTROL, 32'h1);
    `CHK(rd[CB_START], 1'b0)
    $display("test idle done");
    bus(1'b1, ADDR_CONTROL, 32'h0);
    repeat (2) @(posedge hclk);
    `CHK(pins_owned, 1'b0)
    $display("test stop done");
    test_done();
  end
endmodule
`default_nettype wire
